/* mmfs_pkg.sv */
// constants shared by the modem framing and status block
package mmfs_pkg;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_GRESET    = 8'h01;
	localparam logic [7:0] CMD_BASE_U0   = 8'h40;
	localparam logic [7:0] CMD_BASE_U1   = 8'h48;
	localparam logic [7:0] CMD_OFS_CTRL  = 8'h00;
	localparam logic [7:0] CMD_OFS_STAT  = 8'h01;
	localparam logic [7:0] CMD_OFS_RXRD  = 8'h02;
	localparam logic [7:0] CMD_OFS_TXWR  = 8'h03;
	localparam logic [7:0] CMD_OFS_SYNC  = 8'h04;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int         CTL_DIR       = 0;
	localparam int         CTL_CKS       = 1;
	localparam int         CTL_PSAVE     = 2;
	localparam int         CTL_IE        = 3;
	localparam int         CTL_ARM_A     = 4;
	localparam int         CTL_ARM_B     = 5;
	localparam logic [7:0] CTL_MASK      = 8'h3f;
	localparam logic [7:0] CTL_RESET     = 8'h00;

	// ------------------------------------------------------------
	// checksum
	// ------------------------------------------------------------
	localparam logic [14:0] CRC_POLY     = 15'h6816;
	localparam logic [14:0] CRC_INIT     = 15'h0000;
	localparam logic [14:0] CRC_LASTINV  = 15'h0001;
	localparam logic [2:0]  CKS_DATA_BYTES = 3'h6;
	localparam logic [5:0]  RX_CHK_LAST  = 6'h3f;
	localparam logic [5:0]  RX_CHK_INVB  = 6'h3e;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          CLK_HZ       = 200_000_000;
	localparam int          BIT_RATE     = 1200;
	localparam int          BIT_CYCLES   = CLK_HZ / BIT_RATE;
	localparam logic [4:0]  LEFT_BYTE    = 5'h08;
	localparam logic [4:0]  LEFT_WORD    = 5'h10;
	localparam logic [4:0]  LEFT_ONE     = 5'h01;
	localparam logic [2:0]  LAST_BIT     = 3'h7;

	typedef enum logic [0:0] {
		MMFS_TX_IDLE = 1'b0,
		MMFS_TX_SEND = 1'b1
	} mmfs_tx_state_t;

endpackage

/* mmfs_top.sv */
// framing, status and interrupt logic of a half-duplex msk modem
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE1 - sixteen-bit write-only sync pattern, high byte first; compare true and inverse
// RULE2 - host pads short sync patterns with alternating preamble starting with one
// RULE3 - armed search sets status bit 5 on true, bit 4 on inverse, with interrupt
// RULE4 - sync-found bits clear on status read or direction written to transmit
// RULE5 - bit 3 sets after last byte plus hang bit; clears on buffer write or receive
// RULE6 - bit 2 requests next byte; clears on status read then buffer write, or receive
// RULE7 - bit 0 flags received byte; clears on status read then buffer read, or transmit
// RULE8 - host reads each received byte within eight bit periods or loses it
// RULE9 - bit 1 flags checksum match; clears on status read then buffer read, or transmit
// RULE10 - all event interrupts reach the request line only with interrupt enable set
// RULE11 - pending request withdrawn on status read or any direction change
// RULE12 - reset command 01 zeroes control register and returns output to bias level
// RULE13 - reset command leaves status, buffers and sync pattern untouched; the code clears status bits 3 and 2 on it
// RULE14 - divide 48 transmit data bits by the fixed polynomial, 15-bit remainder
// RULE15 - invert last remainder bit, append even parity to form 16-bit check word
// RULE16 - checker inverts bit 63, needs zero remainder and parity equal to bit 64
// RULE17 - armed detector starts at the end of the byte in which arming was written
// RULE18 - detection of either pattern clears both arming bits
// RULE19 - receive checksum checking suppressed while sync search is active
// RULE20 - output at bias level when nothing is sent or receive is selected
// RULE21 - first byte written after selecting transmit sets byte alignment
// RULE22 - host sends preamble and sync as data with checksum insertion off
// RULE23 - with no further byte, append one hang bit of one, then stop
// RULE24 - checksum enabled in transmit inserts two check bytes after six data bytes
// RULE25 - checksum enabled in receive evaluates after every eight received bytes
// RULE26 - interrupt enable gates the active-low request line
// RULE27 - unit select low uses codes 40 to 44, high uses 48 to 4c
// RULE28 - control bit 0 direction, bit 1 checksum enable, bit 3 interrupt enable
// RULE29 - request line stays low while an enabled event is pending
module mmfs_top import mmfs_pkg::*; #(
	parameter int BIT_CYCLES_P = BIT_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// unit select pin
	input  wire logic        unit_sel,
	// host command port
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [7:0]  cmd_data,
	output var  logic [7:0]  reply_data_q,
	output var  logic        reply_valid_q,
	// interrupt request
	output var  logic        irq_n_q,
	// modulator side
	output var  logic        tx_bit_q,
	output var  logic        tx_drive_q,
	output var  logic        mid_bias_level_q,
	// demodulator side
	input  wire logic        rx_bit,
	input  wire logic        rx_strobe
);

	localparam int TW = $clog2(BIT_CYCLES_P + 1);

	initial begin
		if (BIT_CYCLES_P < 2)
			$error("BIT_CYCLES_P must be at least 2");
	end

	function automatic logic [14:0] crc_step(input logic [14:0] r, input logic b);
		logic fb;
		fb = b ^ r[14];
		return {r[13:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
	endfunction

	function automatic logic [14:0] crc_byte(input logic [14:0] r, input logic [7:0] d);
		logic [14:0] t;
		t = r;
		for (int i = 7; i >= 0; i--)
			t = crc_step(t, d[i]);
		return t;
	endfunction

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic       usel_meta_q;
	logic       usel_q;
	logic [7:0] base;
	logic [7:0] ofs;
	logic       hit;
	logic       is_ctrl, is_stat, is_rxrd, is_txwr, is_sync, is_greset;
	logic       to_tx, to_rx, dir_chg;
	logic [7:0] ctrl_q;
	logic [15:0] sync_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			usel_meta_q <= 1'b0;
			usel_q      <= 1'b0;
		end else begin
			usel_meta_q <= unit_sel;
			usel_q      <= usel_meta_q;
		end
	end

	assign base      = usel_q ? CMD_BASE_U1 : CMD_BASE_U0;                 // [RULE27]
	assign ofs       = cmd_code - base;
	assign hit       = cmd_valid && (cmd_code >= base) && (ofs <= CMD_OFS_SYNC);
	assign is_ctrl   = hit && ofs == CMD_OFS_CTRL;
	assign is_stat   = hit && ofs == CMD_OFS_STAT;
	assign is_rxrd   = hit && ofs == CMD_OFS_RXRD;
	assign is_txwr   = hit && ofs == CMD_OFS_TXWR;
	assign is_sync   = hit && ofs == CMD_OFS_SYNC;
	assign is_greset = cmd_valid && cmd_code == CMD_GRESET;
	assign to_tx     = is_ctrl && cmd_data[CTL_DIR];
	assign to_rx     = (is_ctrl && !cmd_data[CTL_DIR]) || is_greset;
	assign dir_chg   = (is_ctrl && cmd_data[CTL_DIR] != ctrl_q[CTL_DIR])
	                 || (is_greset && ctrl_q[CTL_DIR]);                      // [RULE11]

	// ------------------------------------------------------------
	// control and sync pattern registers
	// ------------------------------------------------------------
	logic dir, cks_en, ie, arm;
	logic det_true, det_inv;

	assign dir    = ctrl_q[CTL_DIR];                                        // [RULE28]
	assign cks_en = ctrl_q[CTL_CKS];
	assign ie     = ctrl_q[CTL_IE];
	assign arm    = ctrl_q[CTL_ARM_A] || ctrl_q[CTL_ARM_B];

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			ctrl_q <= CTL_RESET;
		else if (is_greset)
			ctrl_q <= CTL_RESET;                                            // [RULE12]
		else if (is_ctrl)
			ctrl_q <= cmd_data & CTL_MASK;
		else if (det_true || det_inv) begin
			ctrl_q[CTL_ARM_A] <= 1'b0;                                      // [RULE18]
			ctrl_q[CTL_ARM_B] <= 1'b0;
		end
	end

	// general reset does not touch this register
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sync_q <= 16'h0000;
		else if (is_sync)
			sync_q <= {sync_q[7:0], cmd_data};                              // [RULE1] [RULE13]
	end

	// ------------------------------------------------------------
	// transmit sequencer
	// ------------------------------------------------------------
	mmfs_tx_state_t tx_st_q;
	logic [TW-1:0]  tx_cnt_q;
	logic [15:0]    tx_sh_q;
	logic [4:0]     tx_left_q;
	logic           tx_hang_q;
	logic [7:0]     txbuf_q;
	logic           txbuf_full_q;
	logic [2:0]     tx_bytes_q;
	logic [14:0]    tx_rem_q;
	logic           tx_par_q;
	logic           tick, tx_start, tx_end_bit, load_data, load_check, load_hang, tx_done;
	logic [14:0]    chk_rem;

	assign tick       = tx_st_q == MMFS_TX_SEND && tx_cnt_q == TW'(BIT_CYCLES_P - 1);
	assign tx_start   = dir && tx_st_q == MMFS_TX_IDLE && txbuf_full_q;      // [RULE21]
	assign tx_end_bit = tick && tx_left_q == LEFT_ONE;
	assign tx_done    = tx_end_bit && tx_hang_q;                            // [RULE23]
	assign load_check = tx_end_bit && !tx_hang_q && cks_en && tx_bytes_q == CKS_DATA_BYTES; // [RULE24]
	assign load_data  = tx_start || (tx_end_bit && !tx_hang_q && !load_check && txbuf_full_q);
	assign load_hang  = tx_end_bit && !tx_hang_q && !load_check && !txbuf_full_q;
	assign chk_rem    = tx_rem_q ^ CRC_LASTINV;                             // [RULE15]

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_st_q   <= MMFS_TX_IDLE;
			tx_cnt_q  <= '0;
			tx_sh_q   <= 16'h0000;
			tx_left_q <= 5'h00;
			tx_hang_q <= 1'b0;
		end else if (!dir || is_greset) begin
			tx_st_q   <= MMFS_TX_IDLE;
			tx_hang_q <= 1'b0;
		end else begin
			tx_cnt_q <= (tick || tx_start) ? '0 : tx_cnt_q + TW'(1);
			if (load_data) begin
				tx_st_q   <= MMFS_TX_SEND;
				tx_sh_q   <= {txbuf_q, 8'h00};
				tx_left_q <= LEFT_BYTE;
				tx_hang_q <= 1'b0;
			end else if (load_check) begin
				tx_sh_q   <= {chk_rem, tx_par_q ^ (^chk_rem)};
				tx_left_q <= LEFT_WORD;
			end else if (load_hang) begin
				tx_sh_q   <= 16'h8000;
				tx_left_q <= LEFT_ONE;
				tx_hang_q <= 1'b1;
			end else if (tx_done) begin
				tx_st_q   <= MMFS_TX_IDLE;
				tx_hang_q <= 1'b0;
			end else if (tick) begin
				tx_sh_q   <= {tx_sh_q[14:0], 1'b0};
				tx_left_q <= tx_left_q - LEFT_ONE;
			end
		end
	end

	// checksum accumulation over transmitted data bytes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_bytes_q <= 3'h0;
			tx_rem_q   <= CRC_INIT;
			tx_par_q   <= 1'b0;
		end else if (!cks_en || load_check) begin
			tx_bytes_q <= 3'h0;
			tx_rem_q   <= CRC_INIT;
			tx_par_q   <= 1'b0;
		end else if (load_data) begin
			tx_bytes_q <= tx_bytes_q + 3'h1;
			tx_rem_q   <= crc_byte(tx_rem_q, txbuf_q);                      // [RULE14]
			tx_par_q   <= tx_par_q ^ (^txbuf_q);
		end
	end

	// buffer write wins over the load of the previous byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			txbuf_q      <= 8'h00;
			txbuf_full_q <= 1'b0;
		end else if (is_txwr) begin
			txbuf_q      <= cmd_data;
			txbuf_full_q <= 1'b1;
		end else if (load_data || !dir)
			txbuf_full_q <= 1'b0;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_bit_q         <= 1'b0;
			tx_drive_q       <= 1'b0;
			mid_bias_level_q <= 1'b1;
		end else begin
			tx_bit_q         <= tx_sh_q[15];
			tx_drive_q       <= dir && !is_greset && tx_st_q == MMFS_TX_SEND;
			mid_bias_level_q <= !(dir && !is_greset && tx_st_q == MMFS_TX_SEND); // [RULE20] [RULE12]
		end
	end

	// ------------------------------------------------------------
	// receive framing, sync search and checksum check
	// ------------------------------------------------------------
	logic [15:0] rx_hist_q;
	logic [15:0] hist_n;
	logic [2:0]  rx_bitcnt_q;
	logic        search_q;
	logic [7:0]  rxbuf_q;
	logic [5:0]  rx_idx_q;
	logic [14:0] rx_rem_q;
	logic        rx_par_q;
	logic        rx_bit_ev, byte_done, chk_on, crc_ok_ev, rx_byte_ev;

	assign rx_bit_ev  = rx_strobe && !dir;
	assign hist_n     = {rx_hist_q[14:0], rx_bit};
	assign byte_done  = rx_bit_ev && rx_bitcnt_q == LAST_BIT;
	assign det_true   = rx_bit_ev && search_q && arm && hist_n == sync_q;  // [RULE1] [RULE3]
	assign det_inv    = rx_bit_ev && search_q && arm && hist_n == ~sync_q;
	assign rx_byte_ev = byte_done && !search_q;
	assign chk_on     = cks_en && !arm;                                     // [RULE19]
	assign crc_ok_ev  = rx_bit_ev && chk_on && rx_idx_q == RX_CHK_LAST
	                 && rx_rem_q == CRC_INIT && rx_par_q == rx_bit;          // [RULE16] [RULE25]

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_hist_q   <= 16'h0000;
			rx_bitcnt_q <= 3'h0;
			search_q    <= 1'b0;
			rxbuf_q     <= 8'h00;
		end else begin
			if (!arm)
				search_q <= 1'b0;
			else if (byte_done)
				search_q <= 1'b1;                                           // [RULE17]
			if (rx_bit_ev) begin
				rx_hist_q   <= hist_n;
				rx_bitcnt_q <= (det_true || det_inv) ? 3'h0 : rx_bitcnt_q + 3'h1;
			end
			if (det_true || det_inv)
				search_q <= 1'b0;
			if (rx_byte_ev)
				rxbuf_q <= hist_n[7:0];                                     // [RULE8]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_idx_q <= 6'h00;
			rx_rem_q <= CRC_INIT;
			rx_par_q <= 1'b0;
		end else if (!chk_on || det_true || det_inv
		             || (rx_bit_ev && rx_idx_q == RX_CHK_LAST)) begin
			rx_idx_q <= 6'h00;
			rx_rem_q <= CRC_INIT;
			rx_par_q <= 1'b0;
		end else if (rx_bit_ev) begin
			rx_idx_q <= rx_idx_q + 6'h01;
			rx_rem_q <= crc_step(rx_rem_q, rx_bit ^ (rx_idx_q == RX_CHK_INVB)); // [RULE16]
			rx_par_q <= rx_par_q ^ rx_bit;
		end
	end

	// ------------------------------------------------------------
	// status flags, set wins over clear, general reset clears only bits 3 and 2
	// ------------------------------------------------------------
	logic st_true_q, st_inv_q, st_idle_q, st_txreq_q, st_crc_q, st_rxrdy_q;
	logic rd_tx_q, rd_rx_q;
	logic irq_pend_q;
	logic any_ev;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_true_q  <= 1'b0;
			st_inv_q   <= 1'b0;
			st_idle_q  <= 1'b0;
			st_txreq_q <= 1'b0;
			st_crc_q   <= 1'b0;
			st_rxrdy_q <= 1'b0;
		end else begin
			st_true_q  <= det_true || (st_true_q && !is_stat && !to_tx);    // [RULE3] [RULE4]
			st_inv_q   <= det_inv || (st_inv_q && !is_stat && !to_tx);
			st_idle_q  <= tx_done || (st_idle_q && !is_txwr && !to_rx);     // [RULE5]
			st_txreq_q <= load_data || (st_txreq_q && !(is_txwr && rd_tx_q) && !to_rx); // [RULE6]
			st_crc_q   <= crc_ok_ev || (st_crc_q && !(is_rxrd && rd_rx_q) && !to_tx);   // [RULE9]
			st_rxrdy_q <= rx_byte_ev || (st_rxrdy_q && !(is_rxrd && rd_rx_q) && !to_tx); // [RULE7]
		end
	end

	// a status read arms the clear that the following buffer access completes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_tx_q <= 1'b0;
			rd_rx_q <= 1'b0;
		end else begin
			rd_tx_q <= is_stat || (rd_tx_q && !is_txwr);
			rd_rx_q <= is_stat || (rd_rx_q && !is_rxrd);
		end
	end

	// ------------------------------------------------------------
	// interrupt request and replies
	// ------------------------------------------------------------
	assign any_ev = det_true || det_inv || tx_done || load_data || rx_byte_ev || crc_ok_ev;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_pend_q <= 1'b0;
			irq_n_q    <= 1'b1;
		end else begin
			irq_pend_q <= (any_ev && ie) || (irq_pend_q && !is_stat && !dir_chg); // [RULE10] [RULE11] [RULE29]
			irq_n_q    <= !(irq_pend_q && ie);                              // [RULE26]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reply_data_q  <= 8'h00;
			reply_valid_q <= 1'b0;
		end else begin
			reply_valid_q <= is_stat || is_rxrd;
			if (is_stat)
				reply_data_q <= {2'b00, st_true_q, st_inv_q, st_idle_q, st_txreq_q, st_crc_q, st_rxrdy_q};
			else if (is_rxrd)
				reply_data_q <= rxbuf_q;
		end
	end

endmodule // mmfs_top

`default_nettype wire

/* mmfs_top_sva.sv */
// assertions on the ports of the framing and status block
`timescale 1ns/10ps
`default_nettype none
module mmfs_top_sva import mmfs_pkg::*; #(
	parameter int BIT_CYCLES_P = BIT_CYCLES
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// host side
	input wire logic       unit_sel,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_data,
	input wire logic       reply_valid_q,
	input wire logic       irq_n_q,
	// line side
	input wire logic       tx_bit_q,
	input wire logic       tx_drive_q,
	input wire logic       mid_bias_level_q
);
	logic [2:0]  us_q;
	logic        dir_q;
	logic        ie_q;
	logic [31:0] run_q;
	logic [7:0]  base;
	logic        us_ok;
	logic        grst;
	logic        ctl_wr;
	logic        tx_wr;
	logic        st_rd;
	logic        rd;

	assign base   = us_q[2] ? CMD_BASE_U1 : CMD_BASE_U0;
	assign us_ok  = us_q == {3{unit_sel}};
	assign grst   = cmd_valid && cmd_code == CMD_GRESET;
	assign ctl_wr = cmd_valid && cmd_code == base + CMD_OFS_CTRL;
	assign tx_wr  = cmd_valid && cmd_code == base + CMD_OFS_TXWR;
	assign st_rd  = us_ok && cmd_valid && cmd_code == base + CMD_OFS_STAT;
	assign rd     = st_rd || (us_ok && cmd_valid && cmd_code == base + CMD_OFS_RXRD);

	// shadow of unit select, direction, irq enable and bit run length
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			us_q  <= 3'h0;
			dir_q <= 1'b0;
			ie_q  <= 1'b0;
			run_q <= 32'h0;
		end else begin
			us_q  <= {us_q[1:0], unit_sel};
			run_q <= tx_drive_q ? run_q + 32'h1 : 32'h0;
			if (grst || ctl_wr) begin
				dir_q <= ctl_wr & cmd_data[CTL_DIR];
				ie_q  <= ctl_wr & cmd_data[CTL_IE];
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_launch;
		##3 tx_drive_q;
	endsequence

	read_reply_a: assert property (rd |=> reply_valid_q)
		else $error("no reply after a read");
	bias_level_a: assert property (mid_bias_level_q == !tx_drive_q)
		else $error("bias level disagrees with drive");
	rx_abort_a: assert property ((grst || (ctl_wr && !cmd_data[CTL_DIR])) |-> ##[1:2] !tx_drive_q)
		else $error("sending not stopped");
	irq_read_a: assert property (st_rd |-> ##[1:2] irq_n_q)
		else $error("request kept after status read");
	irq_mask_a: assert property (!ie_q && !$past(ie_q) && !$past(ie_q, 2) |-> irq_n_q)
		else $error("request while disabled");
	tx_start_a: assert property (tx_wr && dir_q && !tx_drive_q && !$past(tx_wr) && !$past(tx_wr, 2)
		|-> s_launch ##0 (tx_bit_q == $past(cmd_data[7], 3)))
		else $error("first bit not launched");
	bit_timing_a: assert property (tx_drive_q && $past(tx_drive_q) && tx_bit_q != $past(tx_bit_q)
		|-> run_q % BIT_CYCLES_P == 0)
		else $error("bit changed off its boundary");
	hang_bit_a: assert property ($fell(tx_drive_q) && !$past(cmd_valid) && !$past(cmd_valid, 2)
		|-> $past(tx_bit_q))
		else $error("last bit not a one");
endmodule // mmfs_top_sva
`default_nettype wire

/* mmfs_line_model.sv */
// line-side model: receive bit source and transmit bit capture
`timescale 1ns/10ps
`default_nettype none
module mmfs_line_model #(
	parameter int BIT_CYCLES_P = 8
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// modulator side of the block
	input  wire logic tx_bit,
	input  wire logic tx_drive,
	// recovered receive stream
	output var  logic rx_bit,
	output var  logic rx_strobe
);
	logic txq[$];
	int   run_q = 0;

	initial begin
		rx_bit    = 1'b0;
		rx_strobe = 1'b0;
	end

	// sample each sent bit in mid period
	always @(posedge clk) begin
		run_q <= (tx_drive && !reset) ? run_q + 1 : 0;
		if (tx_drive && run_q % BIT_CYCLES_P == BIT_CYCLES_P / 2)
			txq.push_back(tx_bit);
	end

	// msb first, one strobe a bit; line inverted between strobes
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(negedge clk);
			rx_bit    = b[i];
			rx_strobe = 1'b1;
			@(negedge clk);
			rx_strobe = 1'b0;
			rx_bit    = ~b[i];
			repeat (BIT_CYCLES_P - 2) @(negedge clk);
		end
	endtask
endmodule // mmfs_line_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the framing and status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
	checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("[ERR] %0t got %0h exp %0h", $time, g, e); \
	end \
end
module tb import mmfs_pkg::*; ;
	localparam int BC = 8;
	logic        clk;
	logic        reset;
	logic        unit_sel;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic [7:0]  cmd_data;
	logic [7:0]  base       = CMD_BASE_U0;
	logic [7:0]  reply_data_q;
	logic        reply_valid_q;
	logic        irq_n_q;
	logic        tx_bit_q;
	logic        tx_drive_q;
	logic        mid_bias_level_q;
	logic        rx_bit;
	logic        rx_strobe;
	logic [47:0] msg;
	logic [63:0] fr;
	int          fail_count = 0;
	int          checks     = 0;
	int          cyc        = 0;

	always #2.5 clk = ~clk;

	mmfs_top #(.BIT_CYCLES_P(BC)) dut (
		.clk(clk), .reset(reset), .unit_sel(unit_sel),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.reply_data_q(reply_data_q), .reply_valid_q(reply_valid_q), .irq_n_q(irq_n_q),
		.tx_bit_q(tx_bit_q), .tx_drive_q(tx_drive_q), .mid_bias_level_q(mid_bias_level_q),
		.rx_bit(rx_bit), .rx_strobe(rx_strobe));

	mmfs_line_model #(.BIT_CYCLES_P(BC)) line (
		.clk(clk), .reset(reset), .tx_bit(tx_bit_q), .tx_drive(tx_drive_q),
		.rx_bit(rx_bit), .rx_strobe(rx_strobe));

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			test_done();
		end
	end

	// ----------------------------------------
	// host access and helpers
	// ----------------------------------------
	task automatic cmd(input logic [7:0] c, input logic [7:0] d);
		@(negedge clk);
		cmd_code  = c;
		cmd_data  = d;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask

	task automatic stat(input logic [7:0] e, input logic [7:0] m);
		cmd(base + CMD_OFS_STAT, 8'h00);
		`CHK(reply_valid_q, 1'b1)
		`CHK(reply_data_q & m, e)
	endtask

	// w = 1 waits on drive, w = 0 on the request line
	task automatic wait_for(input int w, input logic v);
		int n;
		n = 0;
		while ((w ? tx_drive_q : irq_n_q) !== v && n < 2000) begin
			@(negedge clk);
			n++;
		end
		`CHK(w ? tx_drive_q : irq_n_q, v)
	endtask

	task automatic chk_tx(input logic [79:0] v, input int n);
		`CHK(line.txq.size(), n)
		for (int i = 0; i < n; i++)
			`CHK(line.txq[i], v[n-1-i])
		line.txq.delete();
	endtask

	function automatic logic [15:0] check_word(input logic [47:0] m);
		logic [14:0] r;
		logic        fb;
		r = CRC_INIT;
		for (int i = 47; i >= 0; i--) begin
			fb = m[i] ^ r[14];
			r  = {r[13:0], 1'b0} ^ (fb ? CRC_POLY : 15'h0000);
		end
		r = r ^ CRC_LASTINV;
		return {r, ^{m, r}};
	endfunction

	task automatic test_done();
		$display("checks %0d errors %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk       = 1'b0;
		reset     = 1'b1;
		unit_sel  = 1'b0;
		cmd_valid = 1'b0;
		cmd_code  = 8'h00;
		cmd_data  = 8'h00;
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		`CHK(mid_bias_level_q, 1'b1)
		`CHK(irq_n_q, 1'b1)
		stat(8'h00, 8'h3f);
		unit_sel = 1'b1;
		repeat (3) @(negedge clk);
		base = CMD_BASE_U1;
		stat(8'h00, 8'h3f);
		cmd(CMD_BASE_U0 + CMD_OFS_STAT, 8'h00);
		`CHK(reply_valid_q, 1'b0)
		unit_sel = 1'b0;
		repeat (3) @(negedge clk);
		base = CMD_BASE_U0;
		// single byte, then two back to back
		cmd(base, 8'h09);
		cmd(base + CMD_OFS_TXWR, 8'ha5);
		wait_for(0, 1'b0);
		stat(8'h04, 8'h3f);
		@(negedge clk);
		`CHK(irq_n_q, 1'b1)
		wait_for(1, 1'b0);
		stat(8'h0c, 8'h3f);
		chk_tx({8'ha5, 1'b1}, 9);
		cmd(base + CMD_OFS_TXWR, 8'h3c);
		stat(8'h04, 8'h3f);
		cmd(base + CMD_OFS_TXWR, 8'h81);
		wait_for(1, 1'b0);
		chk_tx({8'h3c, 8'h81, 1'b1}, 17);
		// six bytes with check word
		cmd(base, 8'h00);
		cmd(base, 8'h0b);
		msg = 48'h123456789abc;
		for (int i = 5; i >= 0; i--) begin
			if (i < 5) begin
				wait_for(0, 1'b0);
				stat(8'h04, 8'h04);
			end
			cmd(base + CMD_OFS_TXWR, msg[i*8 +: 8]);
		end
		wait_for(1, 1'b0);
		chk_tx({msg, check_word(msg), 1'b1}, 65);
		// masked events, then bus-wide reset mid byte
		// twelve-bit sync padded above with preamble
		cmd(base + CMD_OFS_SYNC, 8'hab);
		cmd(base + CMD_OFS_SYNC, 8'h2d);
		cmd(base, 8'h01);
		cmd(base + CMD_OFS_TXWR, 8'hff);
		repeat (20) @(negedge clk);
		`CHK(irq_n_q, 1'b1)
		cmd(CMD_GRESET, 8'h00);
		@(negedge clk);
		`CHK(tx_drive_q, 1'b0)
		`CHK(mid_bias_level_q, 1'b1)
		// true sync with checked frame
		cmd(base, 8'h1a);
		line.send_byte(8'haa);
		line.send_byte(8'haa);
		line.send_byte(8'hab);
		line.send_byte(8'h2d);
		msg = 48'hc3a50f1e7788;
		fr  = {msg, check_word(msg)};
		for (int i = 7; i >= 0; i--)
			line.send_byte(fr[i*8 +: 8]);
		stat(8'h23, 8'h3f);
		cmd(base + CMD_OFS_RXRD, 8'h00);
		`CHK(reply_data_q, fr[7:0])
		stat(8'h00, 8'h3f);
		// inverse sync; true pattern after it must be ignored
		cmd(base, 8'h18);
		line.send_byte(8'haa);
		line.send_byte(8'h54);
		line.send_byte(8'hd2);
		line.send_byte(8'hab);
		line.send_byte(8'h2d);
		stat(8'h10, 8'h32);
		test_done();
	end
endmodule // tb

bind mmfs_top mmfs_top_sva #(.BIT_CYCLES_P(BIT_CYCLES_P)) u_sva (
	.clk(clk), .reset(reset), .unit_sel(unit_sel), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .cmd_data(cmd_data), .reply_valid_q(reply_valid_q),
	.irq_n_q(irq_n_q), .tx_bit_q(tx_bit_q), .tx_drive_q(tx_drive_q),
	.mid_bias_level_q(mid_bias_level_q));
`default_nettype wire
